// [design/mbi_cfg.svh]
// constants for the host-side bus controller that drives the peripheral's pins
// assumes a 100 MHz clock_i; timing figures are given in ns and rounded up to whole clock cycles of that clock
`ifndef MBI_CFG_SVH
`define MBI_CFG_SVH
`define MBI_CLK_NS        10
`define MBI_STROBE_NS     30
`define MBI_STROBE_CYC    ((`MBI_STROBE_NS + `MBI_CLK_NS - 1) / `MBI_CLK_NS)
`define MBI_CNT_W         4
`define MBI_BYTE_W        8
`define MBI_ADDR_W        16
`define MBI_XADDR_W       3
`define MBI_LO_BYTE       7:0
`define MBI_HI_BYTE       15:8
`define MBI_XADDR_FIELD   18:16
`define MBI_TOP_BIT       19
`define MBI_PIN_LO        7:0
`define MBI_PIN_HI        15:8
`define MBI_PIN_PA        23:16
`define MBI_PIN_PB        31:24
`define MBI_MODE_MUX8     2'h0
`define MBI_MODE_MUX16    2'h1
`define MBI_MODE_NMUX8    2'h2
`define MBI_MODE_NMUX16   2'h3
`endif

// [design/mbi_pkg.sv]
// types shared by the host-side bus controller
// assumes mbi_cfg.svh supplies the numeric constants
`include "mbi_cfg.svh"
package mbi_pkg;
    typedef logic [1:0] mbi_mode_t;
    typedef enum logic [2:0] {
        MBI_IDLE   = 3'b000,
        MBI_ADDR   = 3'b001,
        MBI_LATCH  = 3'b010,
        MBI_STROBE = 3'b011,
        MBI_DONE   = 3'b100
    } mbi_state_t;
endpackage

// [design/mbi_step_count.sv]
// small down-counter that times each phase of a bus cycle
// assumes load and count come from the same clock domain
`timescale 1ns/1ps
`default_nettype none
`include "mbi_cfg.svh"
module mbi_step_count (
    // clock and reset
    input  wire logic                  clock_i,
    input  wire logic                  reset_n_i,
    // control
    input  wire logic                  load_i,
    input  wire logic [`MBI_CNT_W-1:0] value_i,
    output logic                       zero_o
);
    logic [`MBI_CNT_W-1:0] count;

    // load wins over counting so a new phase always starts full
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count <= '0;
        end else if (load_i) begin
            count <= value_i;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    assign zero_o = (count == '0);
endmodule // mbi_step_count
`default_nettype wire

// [design/mbi_host.sv]
// host-side controller that runs read and write cycles on the peripheral's pins
// assumes the peripheral is wired as the chosen mode says; one clock, no bus
// Functional notes
// - non-mux 8: data travels on the first general port
// - non-mux 16: low byte first port, high byte second port
// - address bits 16-18 go to third port, bit 19 to top line
// - other-byte multiplexing is wired non-mux; strobe still latches address
`timescale 1ns/1ps
`default_nettype none
`include "mbi_cfg.svh"
module mbi_host
    import mbi_pkg::*;
(
    // clock and reset
    input  wire logic                      clock_i,
    input  wire logic                      reset_n_i,
    // configuration
    input  wire mbi_pkg::mbi_mode_t        mode_i,
    input  wire logic                      width16_ok_i,
    input  wire logic                      strobe_high_i,
    // user request
    input  wire logic                      req_i,
    input  wire logic                      write_i,
    input  wire logic [19:0]               addr_i,
    input  wire logic [15:0]               wdata_i,
    input  wire logic                      hi_byte_i,
    output logic                           busy_o,
    output logic                           done_o,
    output logic [15:0]                    rdata_o,
    // control pins toward the peripheral
    output logic                           address_strobe_o,
    output logic                           read_n_o,
    output logic                           write_n_o,
    output logic                           byte_high_enable_n_o,
    output logic                           top_address_or_chip_select_o,
    output logic [`MBI_XADDR_W-1:0]        third_general_port_o,
    // address/data lines
    input  wire logic [7:0]                low_addr_data_lines_i,
    output logic [7:0]                     low_addr_data_lines_o,
    output logic                           low_addr_data_lines_oe_o,
    input  wire logic [7:0]                high_addr_data_lines_i,
    output logic [7:0]                     high_addr_data_lines_o,
    output logic                           high_addr_data_lines_oe_o,
    // general ports used as data bus in non-mux modes
    input  wire logic [7:0]                first_general_port_i,
    output logic [7:0]                     first_general_port_o,
    output logic                           first_general_port_oe_o,
    input  wire logic [7:0]                second_general_port_i,
    output logic [7:0]                     second_general_port_o,
    output logic                           second_general_port_oe_o
);
    import mbi_pkg::*;

    typedef struct packed {
        mbi_state_t     state;
        logic           mux;
        logic           wide;
        logic           write;
        logic [15:0]    wdata;
        logic           done;
        logic           busy;
        logic [15:0]    rdata;
        logic           strobe;
        logic           rd_n;
        logic           wr_n;
        logic           bhe_n;
        logic           top;
        logic [2:0]     xaddr;
        logic [7:0]     lo_o;
        logic           lo_oe;
        logic [7:0]     hi_o;
        logic           hi_oe;
        logic [7:0]     pa_o;
        logic           pa_oe;
        logic [7:0]     pb_o;
        logic           pb_oe;
    } mbi_host_state_t;

    mbi_host_state_t s;
    mbi_host_state_t next_s;

    // input pins pass two flops before logic reads them
    logic [31:0] pin_sync1;
    logic [31:0] pin_sync2;
    logic        phase_zero;
    logic        phase_load;

    // decodes the data bytes seen on the pins for a given mode
    function automatic logic [15:0] mbi_read_data(input logic mux, input logic [31:0] pins);
        logic [15:0] d;
        d = mux ? {pins[`MBI_PIN_HI], pins[`MBI_PIN_LO]} : {pins[`MBI_PIN_PB], pins[`MBI_PIN_PA]};
        return d;
    endfunction

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_sync1 <= '0;
            pin_sync2 <= '0;
        end else begin
            pin_sync1 <= {second_general_port_i, first_general_port_i,
                          high_addr_data_lines_i, low_addr_data_lines_i};
            pin_sync2 <= pin_sync1;
        end
    end

    // every phase lasts at least the strobe time
    mbi_step_count u_step (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .load_i    (phase_load),
        .value_i   (`MBI_CNT_W'(`MBI_STROBE_CYC)),
        .zero_o    (phase_zero)
    );

    // sequencer: drive address, strobe it, run the data phase, release
    always_comb begin
        next_s = s;
        phase_load = 1'b0;
        next_s.done = 1'b0;
        unique case (s.state)
            MBI_IDLE: begin
                if (req_i) begin
                    next_s.mux = (mode_i == `MBI_MODE_MUX8) || (mode_i == `MBI_MODE_MUX16);
                    next_s.wide = width16_ok_i &&
                        ((mode_i == `MBI_MODE_MUX16) || (mode_i == `MBI_MODE_NMUX16));
                    next_s.write = write_i;
                    next_s.wdata = wdata_i;
                    next_s.busy = 1'b1;
                    next_s.lo_o = addr_i[`MBI_LO_BYTE];
                    next_s.lo_oe = 1'b1;
                    next_s.hi_o = addr_i[`MBI_HI_BYTE];
                    next_s.hi_oe = 1'b1;
                    // third port only ever carries address inputs, never a decoder output
                    next_s.xaddr = addr_i[`MBI_XADDR_FIELD];
                    next_s.top = addr_i[`MBI_TOP_BIT];
                    next_s.bhe_n = ~hi_byte_i;
                    next_s.strobe = strobe_high_i;
                    next_s.state = MBI_ADDR;
                    phase_load = 1'b1;
                end
            end
            MBI_ADDR: begin
                // trailing edge of the strobe closes the device's address latch
                if (phase_zero) begin
                    next_s.strobe = ~strobe_high_i;
                    next_s.state = MBI_LATCH;
                    phase_load = 1'b1;
                end
            end
            MBI_LATCH: begin
                if (phase_zero) begin
                    if (s.mux) begin
                        // release or turn the shared lines toward data
                        next_s.lo_o = s.wdata[`MBI_LO_BYTE];
                        next_s.lo_oe = s.write;
                        if (s.wide) begin
                            next_s.hi_o = s.wdata[`MBI_HI_BYTE];
                            next_s.hi_oe = s.write;
                        end
                    end else begin
                        next_s.pa_o = s.wdata[`MBI_LO_BYTE];
                        next_s.pa_oe = s.write;
                        next_s.pb_o = s.wdata[`MBI_HI_BYTE];
                        // second port stays with the device's direction bits and chip selects unless wide data needs it
                        next_s.pb_oe = s.write && s.wide;
                    end
                    next_s.rd_n = s.write;
                    next_s.wr_n = ~s.write;
                    next_s.state = MBI_STROBE;
                    phase_load = 1'b1;
                end
            end
            MBI_STROBE: begin
                if (phase_zero) begin
                    if (!s.write) begin
                        next_s.rdata = mbi_read_data(s.mux, pin_sync2);
                        if (!s.wide) begin
                            next_s.rdata[`MBI_HI_BYTE] = 8'h00;
                        end
                    end
                    next_s.rd_n = 1'b1;
                    next_s.wr_n = 1'b1;
                    next_s.state = MBI_DONE;
                    phase_load = 1'b1;
                end
            end
            MBI_DONE: begin
                // hold data one phase after the strobe for hold time
                if (phase_zero) begin
                    next_s.lo_oe = 1'b0;
                    next_s.hi_oe = 1'b0;
                    next_s.pa_oe = 1'b0;
                    next_s.pb_oe = 1'b0;
                    next_s.bhe_n = 1'b1;
                    next_s.busy = 1'b0;
                    next_s.done = 1'b1;
                    next_s.state = MBI_IDLE;
                end
            end
            default: begin
                next_s = '0;
                next_s.state = MBI_IDLE;
            end
        endcase
    end

    // strobe rests low at reset, which is inactive only when strobe_high_i is set; polarity taken on the first request
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s <= '{state: MBI_IDLE, rd_n: 1'b1, wr_n: 1'b1, bhe_n: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign busy_o = s.busy;
    assign done_o = s.done;
    assign rdata_o = s.rdata;
    assign address_strobe_o = s.strobe;
    assign read_n_o = s.rd_n;
    assign write_n_o = s.wr_n;
    assign byte_high_enable_n_o = s.bhe_n;
    assign top_address_or_chip_select_o = s.top;
    assign third_general_port_o = s.xaddr;
    assign low_addr_data_lines_o = s.lo_o;
    assign low_addr_data_lines_oe_o = s.lo_oe;
    assign high_addr_data_lines_o = s.hi_o;
    assign high_addr_data_lines_oe_o = s.hi_oe;
    assign first_general_port_o = s.pa_o;
    assign first_general_port_oe_o = s.pa_oe;
    assign second_general_port_o = s.pb_o;
    assign second_general_port_oe_o = s.pb_oe;
endmodule // mbi_host
`default_nettype wire

// [dv/mbi_host_sva.sv]
// checker for the host bus controller: cycle timing and pin ownership
// assumes it is bound to mbi_host and sees only its ports
`timescale 1ns/1ps
`default_nettype none
`include "mbi_cfg.svh"
module mbi_host_sva
    import mbi_pkg::*;
(
    // watched ports
    input wire logic                  clock_i,
    input wire logic                  reset_n_i,
    input wire mbi_pkg::mbi_mode_t    mode_i,
    input wire logic                  strobe_high_i,
    input wire logic                  req_i,
    input wire logic                  busy_o,
    input wire logic                  done_o,
    input wire logic                  address_strobe_o,
    input wire logic                  read_n_o,
    input wire logic                  write_n_o,
    input wire logic                  top_address_or_chip_select_o,
    input wire logic [`MBI_XADDR_W-1:0] third_general_port_o,
    input wire logic                  low_addr_data_lines_oe_o,
    input wire logic                  first_general_port_oe_o
);
    import mbi_pkg::*;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    // busy low means idle, so a request in the done cycle is taken and timed as well
    // each phase is a load of three cycles plus the edge that leaves it: four phases of four
    chk_done_time: assert property (req_i && !busy_o |-> ##17 done_o)
        else $error("done not 17 cycles after request");
    chk_busy_span: assert property ($rose(busy_o) |-> ##15 busy_o ##1 !busy_o)
        else $error("busy span wrong");
    chk_strobe_phase: assert property ($rose(busy_o) |-> (address_strobe_o == strobe_high_i) [*4]
        ##1 (address_strobe_o != strobe_high_i)) else $error("address strobe phase wrong");
    chk_data_strobe: assert property ($fell(read_n_o && write_n_o) |-> !(read_n_o && write_n_o) [*4]
        ##1 (read_n_o && write_n_o)) else $error("data strobe length wrong");
    chk_strobe_excl: assert property (read_n_o || write_n_o)
        else $error("read and write strobes both low");
    chk_read_release: assert property (!read_n_o |-> !first_general_port_oe_o
        && !(!mode_i[1] && low_addr_data_lines_oe_o)) else $error("host drives data during read");
    chk_write_drive: assert property (!write_n_o |-> (mode_i[1] ? first_general_port_oe_o
        : low_addr_data_lines_oe_o)) else $error("write data not driven");
    chk_upper_hold: assert property (busy_o && $past(busy_o)
        |-> $stable({third_general_port_o, top_address_or_chip_select_o})) else $error("upper address moved");
    chk_done_pulse: assert property (done_o |-> !busy_o ##1 !done_o)
        else $error("done not a single pulse");
    chk_idle_quiet: assert property (!busy_o |-> read_n_o && write_n_o)
        else $error("data strobe while idle");
endmodule // mbi_host_sva
bind mbi_host mbi_host_sva i_mbi_host_sva (.clock_i, .reset_n_i, .mode_i, .strobe_high_i, .req_i, .busy_o,
    .done_o, .address_strobe_o, .read_n_o, .write_n_o, .top_address_or_chip_select_o, .third_general_port_o,
    .low_addr_data_lines_oe_o, .first_general_port_oe_o);
`default_nettype wire

// [dv/mbi_dev_model.sv]
// behavioural peripheral: latches address, stores and returns data per bus mode
// assumes host drive values and enables arrive as bytes {second, first, high, low}
`timescale 1ns/1ps
`default_nettype none
`include "mbi_cfg.svh"
module mbi_dev_model
    import mbi_pkg::*;
(
    // configuration and control pins
    input  wire mbi_pkg::mbi_mode_t mode_i,
    input  wire logic             strobe_high_i,
    input  wire logic             address_strobe_i,
    input  wire logic             read_n_i,
    input  wire logic             write_n_i,
    input  wire logic             byte_high_enable_n_i,
    // host side of the shared lines
    input  wire logic [31:0]      host_d_i,
    input  wire logic [3:0]       host_oe_i,
    // resolved line levels
    output logic [31:0]           line_o
);
    import mbi_pkg::*;
    logic [15:0] mem [256];
    logic [15:0] lat;
    logic [7:0]  ix;
    logic [3:0]  drv;
    logic [31:0] dat;
    // transparent latch, closes on the trailing strobe edge
    always_latch begin
        if (address_strobe_i == strobe_high_i) begin
            lat <= host_d_i[15:0];
        end
    end
    // non-mux modes read the address straight off the lines
    assign ix = mode_i[1] ? host_d_i[7:0] : lat[7:0];
    // store on the trailing write edge; narrow modes keep the low byte only
    always @(posedge write_n_i) begin
        mem[ix][7:0] <= mode_i[1] ? host_d_i[23:16] : host_d_i[7:0];
        if (mode_i[0] && !byte_high_enable_n_i) begin
            mem[ix][15:8] <= mode_i[1] ? host_d_i[31:24] : host_d_i[15:8];
        end
    end
    // drive only during a read; a released line shows the inverse so stale values never pass
    assign drv = {!read_n_i && mode_i == `MBI_MODE_NMUX16, !read_n_i && mode_i[1],
                  !read_n_i && mode_i == `MBI_MODE_MUX16, !read_n_i && !mode_i[1]};
    assign dat = {mem[ix], mem[ix]};
    for (genvar k = 0; k < 4; k++) begin : g_line
        assign line_o[8*k+:8] = host_oe_i[k] ? host_d_i[8*k+:8] : drv[k] ? dat[8*k+:8] : ~host_d_i[8*k+:8];
    end
endmodule // mbi_dev_model
`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench: host controller against the peripheral model
// assumes inputs change on the falling edge, one request at a time
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
    import mbi_pkg::*;
    logic        clock_i, reset_n_i, w16, sh, req, wr, hb;
    mbi_mode_t   mode;
    logic [19:0] addr;
    logic [15:0] wd;
    int          miscompares, compares;
    wire logic   busy, done, as, rn, wn, bhn, top;
    wire logic [15:0] rdat;
    wire logic [2:0]  tgp;
    wire logic [31:0] hd, ln;
    wire logic [3:0]  oe;
    wire mbi_mode_t   dmode = {mode[1], mode[0] & w16};
    mbi_host i_mbi_host (.clock_i, .reset_n_i, .mode_i(mode), .width16_ok_i(w16), .strobe_high_i(sh),
        .req_i(req), .write_i(wr), .addr_i(addr), .wdata_i(wd), .hi_byte_i(hb), .busy_o(busy), .done_o(done),
        .rdata_o(rdat), .address_strobe_o(as), .read_n_o(rn), .write_n_o(wn), .byte_high_enable_n_o(bhn),
        .top_address_or_chip_select_o(top), .third_general_port_o(tgp),
        .low_addr_data_lines_i(ln[7:0]), .low_addr_data_lines_o(hd[7:0]), .low_addr_data_lines_oe_o(oe[0]),
        .high_addr_data_lines_i(ln[15:8]), .high_addr_data_lines_o(hd[15:8]), .high_addr_data_lines_oe_o(oe[1]),
        .first_general_port_i(ln[23:16]), .first_general_port_o(hd[23:16]), .first_general_port_oe_o(oe[2]),
        .second_general_port_i(ln[31:24]), .second_general_port_o(hd[31:24]), .second_general_port_oe_o(oe[3]));
    mbi_dev_model i_mbi_dev_model (.mode_i(dmode), .strobe_high_i(sh), .address_strobe_i(as), .read_n_i(rn),
        .write_n_i(wn), .byte_high_enable_n_i(bhn), .host_d_i(hd), .host_oe_i(oe), .line_o(ln));
    always #5 clock_i = ~clock_i;
    // one bus cycle, entered on a falling edge; the next may start in the done cycle
    task automatic cyc(input logic w, input logic [19:0] a, input logic [15:0] d, output logic [15:0] r);
        int n;
        req = 1'b1; wr = w; addr = a; wd = d; hb = mode[0];
        @(negedge clock_i);
        req = 1'b0;
        `CHK({top, tgp}, a[19:16])
        `CHK(bhn, ~hb)
        n = 0;
        while (done !== 1'b1 && n < 40) begin @(negedge clock_i); n++; end
        // four phases, each three counted cycles plus the edge that leaves it
        `CHK(n, 16)
        r = rdat;
    endtask
    task automatic wr_rd(input logic [19:0] a, input logic [15:0] d, input logic [15:0] e);
        logic [15:0] r;
        cyc(1'b1, a, d, r);
        cyc(1'b0, a, 16'h0, r);
        `CHK(r, e)
    endtask
    // every mode, back to back, narrow modes return a zero high byte
    task automatic t_modes;
        logic [15:0] d;
        for (int m = 0; m < 4; m++) begin
            mode = m[1:0];
            d = 16'ha5c3 + 16'(m * 257);
            wr_rd(20'h9a4c0 + 20'(m * 17), d, mode[0] ? d : {8'h00, d[7:0]});
        end
    endtask
    task automatic t_polarity;
        sh = 1'b0; mode = 2'h0;
        wr_rd(20'h12345, 16'h3c5a, 16'h005a);
        sh = 1'b1;
    endtask
    // a variant without the wide bus falls back to eight bits
    task automatic t_narrow;
        w16 = 1'b0; mode = 2'h3;
        wr_rd(20'h0f0f1, 16'hbeef, 16'h00ef);
        w16 = 1'b1;
    endtask
    // request held and changed while busy must be ignored
    task automatic t_refuse;
        logic [15:0] r;
        mode = 2'h2; req = 1'b1; wr = 1'b1; addr = 20'h00077; wd = 16'h1234;
        @(negedge clock_i);
        addr = 20'h00088; wd = 16'h5678;
        repeat (5) @(negedge clock_i);
        req = 1'b0;
        repeat (11) @(negedge clock_i);
        `CHK(done, 1'b1)
        cyc(1'b0, 20'h00077, 16'h0, r);
        `CHK(r, 16'h0034)
    endtask
    task automatic tally_and_finish;
        if (miscompares == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        clock_i = 0; reset_n_i = 0; w16 = 1; sh = 1; req = 0; wr = 0; hb = 0; mode = 0; addr = 0; wd = 0;
        repeat (2) @(negedge clock_i);
        reset_n_i = 1'b1;
        t_modes; t_polarity; t_narrow; t_refuse;
        tally_and_finish;
    end
    // whole run is a few hundred cycles; this cuts a hang short
    initial begin
        #20000;
        miscompares++;
        tally_and_finish;
    end
endmodule // tb_top
`default_nettype wire
